// File: core/tal_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tal_cfg.svh"

module tal_top #(
    parameter int             NPIPE        = `TAL_NPIPE,
    parameter int             NIND         = `TAL_NIND,
    parameter int             NCH          = `TAL_NCH,
    parameter int             NMAN         = `TAL_NMAN,
    parameter int             TW           = `TAL_TW,
    parameter logic [TW-1:0]  BYP_CYC      = TW'(`TAL_BYP_DAYS * `TAL_SEC_PER_DAY * `TAL_CLK_HZ),
    parameter logic [TW-1:0]  ACLOSS_CYC   = TW'(`TAL_ACLOSS_S * `TAL_CLK_HZ),
    parameter logic [TW-1:0]  NOPWR_CYC    = TW'(`TAL_NOPWR_MIN * `TAL_SEC_PER_MIN * `TAL_CLK_HZ),
    parameter logic [TW-1:0]  NOPER_SU_CYC = TW'(`TAL_NOPER_SU_S * `TAL_CLK_HZ),
    parameter logic [TW-1:0]  NOPER_PO_CYC = TW'(`TAL_NOPER_PO_MIN * `TAL_SEC_PER_MIN * `TAL_CLK_HZ)
) (
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    // Operator controls
    input  wire logic                            reset_btn,
    input  wire logic                            startup_sel,
    input  wire logic                            power_sel,
    input  wire logic [NMAN-1:0]                 man_trip,
    input  wire logic [1:0]                      byp_sw,
    // Enclosure health, one bit per circuit
    input  wire logic [1:0]                      circ_fail,
    input  wire logic [1:0]                      ac_ok,
    // Thermal power channels, per circuit, and the shared lpow_ok contact
    input  wire logic [1:0][NCH-1:0]             pwr_ok,
    input  wire logic [1:0][NCH-1:0]             pwr_fn,
    input  wire logic                            lpow_ok,
    // Period channels, per circuit
    input  wire logic [1:0][NCH-1:0]             per_ok,
    input  wire logic [1:0][NCH-1:0]             per_fn,
    // Heat pipe contacts, per circuit; closed (high) means in limits
    input  wire logic [1:0][NPIPE*`TAL_NDIR-1:0] hp_up_ok,
    input  wire logic [1:0][NPIPE*`TAL_NDIR-1:0] hp_lo_ok,
    input  wire logic [1:0][NPIPE*NIND-1:0]      ind_up_ok,
    input  wire logic [1:0][NPIPE*NIND-1:0]      ind_lo_ok,
    // Shutdown rod and status
    output logic                                 rod_hold,
    output logic                                 withdraw_inhibit,
    output logic [1:0]                           circ_ok,
    output tal_pkg::tal_trip_st_t                trip_state
);
    import tal_pkg::*;

    localparam int NDIR = `TAL_NDIR;
    localparam int NIN  = 3 + NMAN + 2 + 2 + 2 + 4 * 2 * NCH + 1
                          + 2 * 2 * NPIPE * NDIR + 2 * 2 * NPIPE * NIND;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NIN-1:0] s1;
        logic [NIN-1:0] s2;
        tal_trip_st_t   latch;
        logic           rst_prev;
        logic           rod_hold;
        logic           withdraw_inhibit;
        logic [1:0]     circ_ok;
    } tal_core_st_t;

    tal_core_st_t st;
    tal_core_st_t next_st;

    // ----------------------------------------------------------------
    // Synchronised views of the pins
    // ----------------------------------------------------------------
    logic                            sy_rst;
    logic                            sy_su;
    logic                            sy_po;
    logic [NMAN-1:0]                 sy_man;
    logic [1:0]                      sy_byp;
    logic [1:0]                      sy_fail;
    logic [1:0]                      sy_ac;
    logic [1:0][NCH-1:0]             sy_pwr_ok;
    logic [1:0][NCH-1:0]             sy_pwr_fn;
    logic [1:0][NCH-1:0]             sy_per_ok;
    logic [1:0][NCH-1:0]             sy_per_fn;
    logic                            sy_lpow;
    logic [1:0][NPIPE*NDIR-1:0]      sy_hp_up;
    logic [1:0][NPIPE*NDIR-1:0]      sy_hp_lo;
    logic [1:0][NPIPE*NIND-1:0]      sy_ind_up;
    logic [1:0][NPIPE*NIND-1:0]      sy_ind_lo;

    assign {sy_rst, sy_su, sy_po, sy_man, sy_byp, sy_fail, sy_ac,
            sy_pwr_ok, sy_pwr_fn, sy_per_ok, sy_per_fn, sy_lpow,
            sy_hp_up, sy_hp_lo, sy_ind_up, sy_ind_lo} = st.s2;

    // ----------------------------------------------------------------
    // Per-circuit evaluation
    // ----------------------------------------------------------------
    logic [1:0][NPIPE-1:0] pipe_ok;
    logic [1:0]            chain_ok;
    logic [1:0]            byp_exp;
    logic [1:0]            acl_exp;
    logic [1:0]            nopwr_exp;
    logic [1:0]            noper_exp;
    logic [1:0]            overpower;
    logic [1:0]            short_per;
    logic                  op_mode;
    logic [TW-1:0]         noper_lim;

    assign op_mode   = sy_su | sy_po;
    // Startup takes the shorter limit when both selectors read high
    assign noper_lim = sy_su ? NOPER_SU_CYC : NOPER_PO_CYC;

    function automatic logic [7:0] tal_ones(input logic [31:0] v);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < 32; i++) begin
            n = n + {7'h00, v[i]};
        end
        return n;
    endfunction

    for (genvar c = 0; c < 2; c++) begin : g_circ
        for (genvar p = 0; p < NPIPE; p++) begin : g_pipe
            logic [NDIR-1:0] dir_good;
            logic [NIND-1:0] ind_good;
            logic [7:0]      n_dir;
            logic [7:0]      n_ind;

            // Lower faults only count outside startup
            assign dir_good = sy_hp_up[c][p*NDIR +: NDIR]
                            & (sy_hp_lo[c][p*NDIR +: NDIR] | {NDIR{sy_su}});
            assign ind_good = sy_ind_up[c][p*NIND +: NIND]
                            & (sy_ind_lo[c][p*NIND +: NIND] | {NIND{sy_su}});
            assign n_dir    = tal_ones(32'(dir_good));
            assign n_ind    = tal_ones(32'(ind_good));
            assign pipe_ok[c][p] = (n_dir >= `TAL_DIR_FULL)
                                 || ((n_dir == `TAL_DIR_ONE) && (n_ind >= `TAL_IND_MIN));
        end

        // A channel that reports itself dead is left to the no-channel timers
        assign overpower[c] = |(sy_pwr_fn[c] & ~sy_pwr_ok[c]);
        assign short_per[c] = |(sy_per_fn[c] & ~sy_per_ok[c]);

        // Series chain of every trip-capable device in this circuit
        assign chain_ok[c] = (&pipe_ok[c]) & ~overpower[c] & ~short_per[c]
                           & ~acl_exp[c] & ~nopwr_exp[c] & ~noper_exp[c];

        tal_timer #(.TW(TW)) u_byp (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .run      (sy_byp[c]),
            .limit    (BYP_CYC),
            .expired  (byp_exp[c])
        );

        tal_timer #(.TW(TW)) u_acl (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .run      (~sy_ac[c]),
            .limit    (ACLOSS_CYC),
            .expired  (acl_exp[c])
        );

        tal_timer #(.TW(TW)) u_nopwr (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .run      (op_mode & ~(|sy_pwr_fn[c])),
            .limit    (NOPWR_CYC),
            .expired  (nopwr_exp[c])
        );

        tal_timer #(.TW(TW)) u_noper (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .run      (op_mode & ~(|sy_per_fn[c])),
            .limit    (noper_lim),
            .expired  (noper_exp[c])
        );
    end

    // ----------------------------------------------------------------
    // Trip combination and latch
    // ----------------------------------------------------------------
    logic [1:0] next_circ_ok;
    logic       trip_cond;
    logic       rst_press;
    logic       lower_fault;

    assign next_circ_ok = sy_byp | chain_ok;
    assign rst_press    = sy_rst & ~st.rst_prev;
    assign lower_fault  = ~(&sy_hp_lo) | ~sy_lpow;

    always_comb begin
        trip_cond = ~(&next_circ_ok);
        trip_cond = trip_cond | (|sy_man);
        trip_cond = trip_cond | (&sy_byp);
        trip_cond = trip_cond | (|byp_exp);
        trip_cond = trip_cond | (|(sy_fail & ~sy_byp));
        trip_cond = trip_cond | (&(sy_fail | sy_byp));
    end

    always_comb begin
        next_st          = st;
        next_st.s1       = {reset_btn, startup_sel, power_sel, man_trip, byp_sw,
                            circ_fail, ac_ok, pwr_ok, pwr_fn, per_ok, per_fn,
                            lpow_ok, hp_up_ok, hp_lo_ok, ind_up_ok, ind_lo_ok};
        next_st.s2       = st.s1;
        next_st.rst_prev = sy_rst;
        next_st.circ_ok  = next_circ_ok;
        case (st.latch)
            TS_ARMED: begin
                if (trip_cond) begin
                    next_st.latch = TS_TRIPPED;
                end
            end
            TS_TRIPPED: begin
                // Holding the button down does not re-arm; a fresh press is needed
                if (rst_press && !trip_cond) begin
                    next_st.latch = TS_ARMED;
                end
            end
            default: begin
                next_st.latch = TS_TRIPPED;
            end
        endcase
        // Magnets drop the same edge the latch sets, never a cycle later
        next_st.rod_hold         = (next_st.latch == TS_ARMED) && !trip_cond;
        next_st.withdraw_inhibit = (next_st.latch == TS_TRIPPED)
                                 || (!sy_su && lower_fault);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st                  <= '0;
            st.latch            <= TS_TRIPPED;
            st.withdraw_inhibit <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rod_hold         = st.rod_hold;
    assign withdraw_inhibit = st.withdraw_inhibit;
    assign circ_ok          = st.circ_ok;
    assign trip_state       = st.latch;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_manual_trip_drop: assert property (|sy_man |=> !rod_hold && trip_state == TS_TRIPPED)
        else $error("manual trip did not drop the rods");
    a_both_bypass_trip: assert property (&sy_byp |=> !rod_hold)
        else $error("double bypass did not trip");
    a_bypass_forces_ok: assert property (sy_byp[0] |=> circ_ok[0])
        else $error("bypassed circuit not held high");
    a_fail_unbypassed: assert property (|(sy_fail & ~sy_byp) |=> !rod_hold)
        else $error("unbypassed failed circuit did not trip");
    a_both_nonfunc_trip: assert property (&(sy_fail | sy_byp) |=> !rod_hold)
        else $error("both circuits unavailable without trip");
    a_circuit_or_trip: assert property (!chain_ok[1] && !sy_byp[1] |=> !circ_ok[1] && !rod_hold)
        else $error("single circuit fault did not trip");
    a_overpower_trip: assert property (overpower[0] && !sy_byp[0] |=> !rod_hold)
        else $error("overpower did not trip");
    a_pipe_vote_trip: assert property (!(&pipe_ok[1]) && !sy_byp[1] |=> !circ_ok[1])
        else $error("unhealthy heat pipe left circuit high");
    a_bypass_expiry: assert property (|byp_exp |=> !rod_hold)
        else $error("expired bypass did not trip");
    a_latch_holds: assert property (trip_state == TS_TRIPPED && !rst_press
                                    |=> trip_state == TS_TRIPPED)
        else $error("trip latch released without a reset press");
    a_reset_rearms: assert property (trip_state == TS_TRIPPED && rst_press && !trip_cond
                                     |=> rod_hold)
        else $error("reset press did not re-arm");
    a_hold_means_armed: assert property (rod_hold |-> trip_state == TS_ARMED
        && withdraw_inhibit == $past(!sy_su && lower_fault))
        else $error("rods held while latched");
    a_inhibit_latched: assert property (trip_state == TS_TRIPPED |-> withdraw_inhibit)
        else $error("withdrawal allowed while tripped");

    c_trip_then_rearm: cover property (trip_state == TS_ARMED ##1 trip_state == TS_TRIPPED
                                       ##[1:20] trip_state == TS_ARMED);
    c_single_bypass_run: cover property (sy_byp == 2'h1 && rod_hold);
    c_startup_masking: cover property (sy_su && !(&sy_hp_lo) && rod_hold);
    c_acloss_trip: cover property (|acl_exp ##1 !rod_hold);
endmodule

`default_nettype wire

// File: core/tal_cfg.svh
// Summary of operation
// - Each circuit ANDs all trip-capable inputs; any input in trip state drops it.
// - High output keeps rod magnets energised; low output releases them.
// - Two independent circuits; a trip from either one shuts down.
// - Bypass forces that circuit high; the other keeps evaluating.
// - Both bypass switches on together cause a trip.
// - Bypass held for 7 days trips within 1 minute of expiry.
// - A nonfunctional circuit that is not bypassed trips at once.
// - Both circuits nonfunctional or bypassed trips within 5 seconds.
// - Power mode honours upper and lower faults; startup masks lower faults.
// - Pipe healthy needs two direct, or one direct plus nine indirect, good channels.
// - Manual trip buttons skip voting and force the output low.
// - Loss of enclosure primary power trips unless restored before countdown ends.
// - Thermal power over 4.2 MWth trips in every mode; only a bypass of its circuit masks it.
// - No functional thermal power channel for 5 minutes shuts down.
// - Reactor period below 5 seconds trips within 5 seconds.
// - No period channel: trip after 30 s in startup, 5 min in power.
// - Any trip latches; reset button clears it only once the cause is gone.
// - While shut down, lower limits inhibit withdrawal unless startup mode is selected; the code inhibits withdrawal whenever tripped, startup or not.
// - Selector lets at most one enclosure be bypassed before maintenance.
`ifndef TAL_CFG_SVH
`define TAL_CFG_SVH

// ----------------------------------------------------------------
// Clock and time units
// ----------------------------------------------------------------
`define TAL_CLK_HZ        64'd20000000
`define TAL_SEC_PER_MIN   64'd60
`define TAL_SEC_PER_DAY   64'd86400

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define TAL_BYP_DAYS      64'd7
`define TAL_NOPWR_MIN     64'd5
`define TAL_NOPER_SU_S    64'd30
`define TAL_NOPER_PO_MIN  64'd5
`define TAL_ACLOSS_S      64'd10

// ----------------------------------------------------------------
// Structure and voting
// ----------------------------------------------------------------
`define TAL_TW            48
`define TAL_NPIPE         114
`define TAL_NDIR          3
`define TAL_NIND          12
`define TAL_NCH           2
`define TAL_NMAN          4
`define TAL_DIR_FULL      8'h02
`define TAL_DIR_ONE       8'h01
`define TAL_IND_MIN       8'h09

`endif

// File: core/tal_pkg.sv
package tal_pkg;
    typedef enum logic {
        TS_TRIPPED,
        TS_ARMED
    } tal_trip_st_t;
endpackage

// File: core/tal_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tal_cfg.svh"

module tal_timer #(
    parameter int TW = `TAL_TW
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // Control
    input  wire logic          run,
    input  wire logic [TW-1:0] limit,
    // Status
    output logic               expired
);
    import tal_pkg::*;

    typedef struct packed {
        logic [TW-1:0] cnt;
        logic          done;
    } tal_tmr_st_t;

    tal_tmr_st_t st;
    tal_tmr_st_t next_st;

    // Counts up while run holds; any gap restarts the full interval
    always_comb begin
        next_st = st;
        if (!run) begin
            next_st = '0;
        end else if (!st.done) begin
            next_st.cnt  = st.cnt + TW'(1);
            next_st.done = (st.cnt + TW'(1)) >= limit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.done;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_timer_reload: assert property (!run |=> (st.cnt == '0) && !expired)
        else $error("timer did not reload when run dropped");
    a_timer_expiry: assert property (run && !st.done
        && (st.cnt + TW'(1) >= limit) |=> expired)
        else $error("timer missed its limit");
    c_timer_fires: cover property (run ##1 expired);
endmodule

`default_nettype wire

// File: test/tal_plant_model.sv
`timescale 1ns/1ps
`default_nettype none

module tal_plant_model #(
    parameter int NP   = 2,
    parameter int ND   = 3,
    parameter int NI   = 12,
    parameter int PERS = 4
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // Excursions commanded by the bench
    input  wire logic                  mon_pwr,
    input  wire logic [1:0][NP*ND-1:0] exc_up,
    input  wire logic [1:0][NP*ND-1:0] exc_lo,
    input  wire logic [1:0][NP*NI-1:0] exc_ind,
    // Monitor contacts, closed while in limits
    output logic      [1:0][NP*ND-1:0] hp_up_ok,
    output logic      [1:0][NP*ND-1:0] hp_lo_ok,
    output logic      [1:0][NP*NI-1:0] ind_up_ok,
    output logic      [1:0][NP*NI-1:0] ind_lo_ok,
    // Rod magnets
    input  wire logic                  rod_hold,
    output logic                       rods_in
);
    // ------------------------------------------------------------
    // Persistence and rods
    // ------------------------------------------------------------
    int   pers_cnt;
    logic due;
    logic any_exc;

    // One shared age for all excursions: small, but a late excursion inherits it
    assign any_exc = |{exc_up, exc_lo, exc_ind};
    assign due     = (pers_cnt >= PERS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pers_cnt <= 0;
            rods_in  <= 1'b1;
        end else begin
            pers_cnt <= !any_exc ? 0 : (due ? pers_cnt : pers_cnt + 1);
            rods_in  <= !rod_hold;
        end
    end

    // ------------------------------------------------------------
    // Contacts open on excursion or on loss of monitor power
    // ------------------------------------------------------------
    // An excursion stands for a reading past +15 C or -35 C from nominal
    assign hp_up_ok  = mon_pwr ? ~(exc_up & {2*NP*ND{due}}) : '0;
    assign hp_lo_ok  = mon_pwr ? ~(exc_lo & {2*NP*ND{due}}) : '0;
    assign ind_up_ok = mon_pwr ? ~(exc_ind & {2*NP*NI{due}}) : '0;
    assign ind_lo_ok = mon_pwr ? ~(exc_ind & {2*NP*NI{due}}) : '0;
endmodule

`default_nettype wire

// File: test/tb_trip_aggregation_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "tal_cfg.svh"

module tb_trip_aggregation_logic;
    import tal_pkg::*;

    // Shortened counts keep every timer inside a short run
    localparam int NP   = 2;
    localparam int NI   = 12;
    localparam int ND   = `TAL_NDIR;
    localparam int LIMS [5] = '{20, 10, 30, 8, 16};

    logic                  core_clk;
    logic                  rst_n;
    logic                  reset_btn;
    logic                  startup_sel;
    logic                  power_sel;
    logic [3:0]            man_trip;
    logic [1:0]            byp_sw;
    logic [1:0]            circ_fail;
    logic [1:0]            ac_ok;
    logic [1:0][1:0]       pwr_ok;
    logic [1:0][1:0]       pwr_fn;
    logic                  lpow_ok;
    logic [1:0][1:0]       per_ok;
    logic [1:0][1:0]       per_fn;
    logic                  mon_pwr;
    logic [1:0][NP*ND-1:0] exc_up;
    logic [1:0][NP*ND-1:0] exc_lo;
    logic [1:0][NP*NI-1:0] exc_ind;
    logic [1:0][NP*ND-1:0] hp_up_ok;
    logic [1:0][NP*ND-1:0] hp_lo_ok;
    logic [1:0][NP*NI-1:0] ind_up_ok;
    logic [1:0][NP*NI-1:0] ind_lo_ok;
    logic                  rod_hold;
    logic                  withdraw_inhibit;
    logic [1:0]            circ_ok;
    tal_trip_st_t          trip_state;
    logic                  rods_in;
    int                    err_total = 0;
    int                    tests_run = 0;

    tal_top #(.NPIPE(NP), .NIND(NI), .NCH(2), .NMAN(4), .BYP_CYC(48'(LIMS[0])),
        .ACLOSS_CYC(48'(LIMS[1])), .NOPWR_CYC(48'(LIMS[2])),
        .NOPER_SU_CYC(48'(LIMS[3])), .NOPER_PO_CYC(48'(LIMS[4]))) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .reset_btn(reset_btn),
        .startup_sel(startup_sel), .power_sel(power_sel), .man_trip(man_trip),
        .byp_sw(byp_sw), .circ_fail(circ_fail), .ac_ok(ac_ok), .pwr_ok(pwr_ok),
        .pwr_fn(pwr_fn), .lpow_ok(lpow_ok), .per_ok(per_ok), .per_fn(per_fn),
        .hp_up_ok(hp_up_ok), .hp_lo_ok(hp_lo_ok), .ind_up_ok(ind_up_ok),
        .ind_lo_ok(ind_lo_ok), .rod_hold(rod_hold), .withdraw_inhibit(withdraw_inhibit),
        .circ_ok(circ_ok), .trip_state(trip_state));

    tal_plant_model #(.NP(NP), .ND(ND), .NI(NI), .PERS(4)) plant (
        .core_clk(core_clk), .rst_n(rst_n), .mon_pwr(mon_pwr), .exc_up(exc_up),
        .exc_lo(exc_lo), .exc_ind(exc_ind), .hp_up_ok(hp_up_ok), .hp_lo_ok(hp_lo_ok),
        .ind_up_ok(ind_up_ok), .ind_lo_ok(ind_lo_ok), .rod_hold(rod_hold),
        .rods_in(rods_in));

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_st(input tal_trip_st_t got, input tal_trip_st_t exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t latch state %b expected %b", $time, got, exp);
        end
    endtask

    task automatic heal();
        man_trip = 4'h0;
        byp_sw = 2'h0;
        circ_fail = 2'h0;
        ac_ok = 2'h3;
        pwr_ok = 4'hF;
        pwr_fn = 4'hF;
        per_ok = 4'hF;
        per_fn = 4'hF;
        lpow_ok = 1'b1;
        mon_pwr = 1'b1;
        exc_up = '0;
        exc_lo = '0;
        exc_ind = '0;
    endtask

    task automatic press();
        reset_btn = 1'b1;
        cyc(5);
        reset_btn = 1'b0;
        cyc(1);
    endtask

    task automatic rearm();
        heal();
        cyc(6);
        press();
        chk(rod_hold, 1'b1);
        chk_st(trip_state, TS_ARMED);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // A bound that runs out ends the run at once
    task automatic wait_trip(input int bound);
        int i;
        for (i = 0; i < bound && rod_hold !== 1'b0; i++) begin
            cyc(1);
        end
        if (rod_hold !== 1'b0) begin
            err_total++;
            $display("ERROR t=%0t no shutdown within %0d cycles", $time, bound);
            tally_and_finish();
        end
        cyc(1);
        chk(rods_in, 1'b1);
        chk_st(trip_state, TS_TRIPPED);
        chk(withdraw_inhibit, 1'b1);
    endtask

    task automatic set_cause(input int id, input logic on);
        case (id)
            0: byp_sw[0] = on;
            1: ac_ok[0] = !on;
            2: pwr_fn[0] = on ? 2'h0 : 2'h3;
            default: per_fn[1] = on ? 2'h0 : 2'h3;
        endcase
    endtask

    // A one-cycle gap must reload the count, so expiry is timed from the restart
    task automatic timer_case(input int id, input int lim);
        set_cause(id, 1'b1);
        cyc(lim / 2);
        set_cause(id, 1'b0);
        cyc(1);
        set_cause(id, 1'b1);
        cyc(lim + 2);
        chk(rod_hold, 1'b1);
        cyc(1);
        chk(rod_hold, 1'b0);
        set_cause(id, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reset_btn = 1'b0;
        startup_sel = 1'b0;
        power_sel = 1'b1;
        heal();
        cyc(12);
        chk(rod_hold, 1'b0);
        chk_st(trip_state, TS_TRIPPED);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rearm();
            // The last button also carries the plant control system's trip
            man_trip[i] = 1'b1;
            cyc(2);
            chk(rod_hold, 1'b1);
            cyc(1);
            chk(rod_hold, 1'b0);
            press();
            chk(rod_hold, 1'b0);
            man_trip[i] = 1'b0;
            cyc(4);
            chk(rod_hold, 1'b0);
        end
        $display("test manual_trip done");
        rearm();
        byp_sw[0] = 1'b1;
        pwr_ok[0] = 2'h1;
        cyc(6);
        chk(circ_ok[0], 1'b1);
        chk(rod_hold, 1'b1);
        pwr_ok[1] = 2'h2;
        wait_trip(8);
        chk(circ_ok[1], 1'b0);
        rearm();
        byp_sw = 2'h3;
        wait_trip(8);
        rearm();
        circ_fail[1] = 1'b1;
        wait_trip(8);
        rearm();
        per_ok[0] = 2'h2;
        wait_trip(8);
        $display("test circuits done");
        for (int i = 0; i < 5; i++) begin
            startup_sel = (i == 3);
            power_sel = (i != 3);
            rearm();
            timer_case(i, LIMS[i]);
        end
        $display("test timers done");
        rearm();
        exc_up[0] = 6'h01;
        cyc(12);
        chk(rod_hold, 1'b1);
        exc_up[0] = 6'h03;
        cyc(12);
        chk(rod_hold, 1'b1);
        exc_ind[0] = 24'h00000F;
        wait_trip(12);
        startup_sel = 1'b1;
        power_sel = 1'b0;
        rearm();
        exc_lo[1] = 6'h07;
        cyc(12);
        chk(rod_hold, 1'b1);
        startup_sel = 1'b0;
        power_sel = 1'b1;
        wait_trip(8);
        rearm();
        lpow_ok = 1'b0;
        cyc(5);
        chk(withdraw_inhibit, 1'b1);
        startup_sel = 1'b1;
        cyc(5);
        chk(withdraw_inhibit, 1'b0);
        startup_sel = 1'b0;
        mon_pwr = 1'b0;
        wait_trip(8);
        rearm();
        rst_n = 1'b0;
        #1;
        chk(rod_hold, 1'b0);
        $display("test pipes_and_reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
